// ### ioc_pkg.sv
`default_nettype none

package ioc_pkg;

    // register offsets inside the on-chip i/o register space
    localparam logic [7:0] OFS_MODE_A = 8'h00;
    localparam logic [7:0] OFS_MODE_B = 8'h01;
    localparam logic [7:0] OFS_DIR_A = 8'h04;
    localparam logic [7:0] OFS_DIR_B = 8'h05;
    localparam logic [7:0] OFS_DIR_C = 8'h06;
    localparam logic [7:0] OFS_DIR_D = 8'h07;
    localparam logic [7:0] OFS_DRV_A = 8'h08;
    localparam logic [7:0] OFS_DRV_B = 8'h09;
    localparam logic [7:0] OFS_DRV_C = 8'h0A;
    localparam logic [7:0] OFS_DRV_D = 8'h0B;
    localparam logic [7:0] OFS_MEM_MAP = 8'h0C;

    // reset value of every configuration register
    localparam logic [7:0] CFG_RESET = 8'h00;

    // field positions
    localparam int PIO_BIT = 7;
    localparam logic [7:0] PIO_MASK = 8'h80;
    localparam int PD_LO_BIT = 1;
    localparam int PD_HI_BIT = 2;
    localparam logic [7:0] PD_USED_MASK = 8'h06;

    // drive-select bit meaning per port
    localparam logic [7:0] SLEW_MASK_AB = 8'h0F;
    localparam logic [7:0] OD_MASK_AB = 8'hF0;
    localparam logic [7:0] OD_MASK_C = 8'hFF;

    // index of a port in the direction and drive arrays
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int NUM_PORTS = 4;

endpackage : ioc_pkg

`default_nettype wire

// ### ioc_port_cfg.sv
// Behaviour
// - memory-map bit 7 makes Port A peripheral buffer
// - buffer off while either peripheral select low
// - program store strobe ANDed into buffer enable
// - register bit n controls pin n only; Port D bits 2 and 1 control pins 1 and 0
// - mode, direction, drive registers reset to zero
// - mode bit 0 I/O, 1 latched address
// - mode register exists for Ports A, B only
// - direction one output, zero input
// - driver on when direction or OE term
// - absent OE term: direction alone decides
// - Port D direction holds only two bits
// - Port D uses only bits 2 and 1
// - drive bit one gives open drain
// - drive bit one gives fast slew
// - slew/open-drain split per port and bit
// - address pins carry latched address bits
// - registers reached by plain bus cycles
// - output from data register, input buffered
`timescale 1ns/10ps
`default_nettype none

module ioc_port_cfg (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic IO_SPACE_SEL,
    input wire logic [7:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    input wire logic [7:0] ADDR_LATCHED,
    input wire logic [7:0] MCU_DATA,
    input wire logic MCU_READ,
    input wire logic PERIPH_SELECT_A,
    input wire logic PERIPH_SELECT_B,
    input wire logic PROGRAM_STORE_STROBE,
    output logic [7:0] PERIPH_RDATA,
    input wire logic [7:0] DOUT_A,
    input wire logic [7:0] DOUT_B,
    input wire logic [7:0] DOUT_C,
    input wire logic [1:0] DOUT_D,
    input wire logic [7:0] OE_TERM_A,
    input wire logic [7:0] OE_TERM_B,
    input wire logic [7:0] OE_TERM_C,
    input wire logic [1:0] OE_TERM_D,
    input wire logic [7:0] PA_IN,
    input wire logic [7:0] PB_IN,
    input wire logic [7:0] PC_IN,
    input wire logic [1:0] PD_IN,
    output logic [7:0] PA_OUT,
    output logic [7:0] PB_OUT,
    output logic [7:0] PC_OUT,
    output logic [1:0] PD_OUT,
    output logic [7:0] PA_OE_N,
    output logic [7:0] PB_OE_N,
    output logic [7:0] PC_OE_N,
    output logic [1:0] PD_OE_N,
    output logic [7:0] PA_SLEW_FAST,
    output logic [7:0] PB_SLEW_FAST,
    output logic [1:0] PD_SLEW_FAST,
    output logic [7:0] DIN_A,
    output logic [7:0] DIN_B,
    output logic [7:0] DIN_C,
    output logic [1:0] DIN_D
);

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [7:0] mode_a_r;
    logic [7:0] mode_a_nxt;
    logic [7:0] mode_b_r;
    logic [7:0] mode_b_nxt;
    logic [7:0] dir_r [ioc_pkg::NUM_PORTS];
    logic [7:0] dir_nxt [ioc_pkg::NUM_PORTS];
    logic [7:0] drv_r [ioc_pkg::NUM_PORTS];
    logic [7:0] drv_nxt [ioc_pkg::NUM_PORTS];
    logic [7:0] mem_map_r;
    logic [7:0] mem_map_nxt;
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = IO_SPACE_SEL & BUS_WR;
    assign rd_hit = IO_SPACE_SEL & BUS_RD;

    always_comb begin
        mode_a_nxt = mode_a_r;
        mode_b_nxt = mode_b_r;
        dir_nxt = dir_r;
        drv_nxt = drv_r;
        mem_map_nxt = mem_map_r;
        if (wr_hit) begin
            unique case (BUS_ADDR)
                ioc_pkg::OFS_MODE_A: mode_a_nxt = BUS_WDATA;
                ioc_pkg::OFS_MODE_B: mode_b_nxt = BUS_WDATA;
                ioc_pkg::OFS_DIR_A: dir_nxt[ioc_pkg::PORT_A] = BUS_WDATA;
                ioc_pkg::OFS_DIR_B: dir_nxt[ioc_pkg::PORT_B] = BUS_WDATA;
                ioc_pkg::OFS_DIR_C: dir_nxt[ioc_pkg::PORT_C] = BUS_WDATA;
                // only the two existing port d pins keep a bit
                ioc_pkg::OFS_DIR_D: dir_nxt[ioc_pkg::PORT_D] = BUS_WDATA & ioc_pkg::PD_USED_MASK;
                ioc_pkg::OFS_DRV_A: drv_nxt[ioc_pkg::PORT_A] = BUS_WDATA;
                ioc_pkg::OFS_DRV_B: drv_nxt[ioc_pkg::PORT_B] = BUS_WDATA;
                ioc_pkg::OFS_DRV_C: drv_nxt[ioc_pkg::PORT_C] = BUS_WDATA;
                ioc_pkg::OFS_DRV_D: drv_nxt[ioc_pkg::PORT_D] = BUS_WDATA & ioc_pkg::PD_USED_MASK;
                // other memory-map bits belong to the decoder, not here
                ioc_pkg::OFS_MEM_MAP: mem_map_nxt = BUS_WDATA & ioc_pkg::PIO_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_a_r <= ioc_pkg::CFG_RESET;
            mode_b_r <= ioc_pkg::CFG_RESET;
            for (int i = 0; i < ioc_pkg::NUM_PORTS; i++) begin
                dir_r[i] <= ioc_pkg::CFG_RESET;
                drv_r[i] <= ioc_pkg::CFG_RESET;
            end
            mem_map_r <= ioc_pkg::CFG_RESET;
        end else if (CLK_EN) begin
            mode_a_r <= mode_a_nxt;
            mode_b_r <= mode_b_nxt;
            dir_r <= dir_nxt;
            drv_r <= drv_nxt;
            mem_map_r <= mem_map_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-back path

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_hit) begin
            unique case (BUS_ADDR)
                ioc_pkg::OFS_MODE_A: rdata_nxt = mode_a_r;
                ioc_pkg::OFS_MODE_B: rdata_nxt = mode_b_r;
                ioc_pkg::OFS_DIR_A: rdata_nxt = dir_r[ioc_pkg::PORT_A];
                ioc_pkg::OFS_DIR_B: rdata_nxt = dir_r[ioc_pkg::PORT_B];
                ioc_pkg::OFS_DIR_C: rdata_nxt = dir_r[ioc_pkg::PORT_C];
                ioc_pkg::OFS_DIR_D: rdata_nxt = dir_r[ioc_pkg::PORT_D];
                ioc_pkg::OFS_DRV_A: rdata_nxt = drv_r[ioc_pkg::PORT_A];
                ioc_pkg::OFS_DRV_B: rdata_nxt = drv_r[ioc_pkg::PORT_B];
                ioc_pkg::OFS_DRV_C: rdata_nxt = drv_r[ioc_pkg::PORT_C];
                ioc_pkg::OFS_DRV_D: rdata_nxt = drv_r[ioc_pkg::PORT_D];
                ioc_pkg::OFS_MEM_MAP: rdata_nxt = mem_map_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 8'h00;
        end else if (CLK_EN) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign BUS_RDATA = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // pin drivers and input buffers

    logic buf_on;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    logic [1:0] en_d;
    logic [7:0] data_a;
    logic [7:0] data_b;
    logic [7:0] od_a;
    logic [7:0] od_b;
    logic [7:0] od_c;
    logic [1:0] drv_d;
    logic [7:0] pa_out_nxt;
    logic [7:0] pb_out_nxt;
    logic [7:0] pc_out_nxt;
    logic [1:0] pd_out_nxt;
    logic [7:0] pa_oe_n_nxt;
    logic [7:0] pb_oe_n_nxt;
    logic [7:0] pc_oe_n_nxt;
    logic [1:0] pd_oe_n_nxt;
    logic [7:0] periph_nxt;
    logic [7:0] pa_slew_nxt;
    logic [7:0] pb_slew_nxt;
    logic [1:0] pd_slew_nxt;
    logic [7:0] din_a_nxt;
    logic [7:0] din_b_nxt;
    logic [7:0] din_c_nxt;
    logic [1:0] din_d_nxt;

    // a pin set to open drain never drives high; the pull-up does that
    always_comb begin
        // selects and strobe all true means a program-space peripheral cycle
        buf_on = PERIPH_SELECT_A & PERIPH_SELECT_B & PROGRAM_STORE_STROBE;
        en_a = dir_r[ioc_pkg::PORT_A] | OE_TERM_A;
        en_b = dir_r[ioc_pkg::PORT_B] | OE_TERM_B;
        en_c = dir_r[ioc_pkg::PORT_C] | OE_TERM_C;
        en_d = dir_r[ioc_pkg::PORT_D][ioc_pkg::PD_HI_BIT:ioc_pkg::PD_LO_BIT] | OE_TERM_D;
        data_a = (mode_a_r & ADDR_LATCHED) | (~mode_a_r & DOUT_A);
        data_b = (mode_b_r & ADDR_LATCHED) | (~mode_b_r & DOUT_B);
        od_a = drv_r[ioc_pkg::PORT_A] & ioc_pkg::OD_MASK_AB;
        od_b = drv_r[ioc_pkg::PORT_B] & ioc_pkg::OD_MASK_AB;
        od_c = drv_r[ioc_pkg::PORT_C] & ioc_pkg::OD_MASK_C;
        drv_d = drv_r[ioc_pkg::PORT_D][ioc_pkg::PD_HI_BIT:ioc_pkg::PD_LO_BIT];
        periph_nxt = 8'h00;
        if (mem_map_r[ioc_pkg::PIO_BIT]) begin
            // whole port a follows the mcu bus; open drain does not apply
            en_a = {8{buf_on & ~MCU_READ}};
            data_a = MCU_DATA;
            od_a = 8'h00;
            if (buf_on & MCU_READ) begin
                periph_nxt = PA_IN;
            end
        end
        pd_out_nxt = DOUT_D;
        pd_oe_n_nxt = ~en_d;
        pa_slew_nxt = drv_r[ioc_pkg::PORT_A] & ioc_pkg::SLEW_MASK_AB;
        pb_slew_nxt = drv_r[ioc_pkg::PORT_B] & ioc_pkg::SLEW_MASK_AB;
        pd_slew_nxt = drv_d;
        din_a_nxt = PA_IN;
        din_b_nxt = PB_IN;
        din_c_nxt = PC_IN;
        din_d_nxt = PD_IN;
    end

    // ports a to c share one driver cell; port d has no open drain
    ioc_pin_drv #(.W(8)) pin_drv_a (
        .en(en_a),
        .data(data_a),
        .od(od_a),
        .pin_out(pa_out_nxt),
        .pin_oe_n(pa_oe_n_nxt)
    );

    ioc_pin_drv #(.W(8)) pin_drv_b (
        .en(en_b),
        .data(data_b),
        .od(od_b),
        .pin_out(pb_out_nxt),
        .pin_oe_n(pb_oe_n_nxt)
    );

    ioc_pin_drv #(.W(8)) pin_drv_c (
        .en(en_c),
        .data(DOUT_C),
        .od(od_c),
        .pin_out(pc_out_nxt),
        .pin_oe_n(pc_oe_n_nxt)
    );

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PA_OUT <= 8'h00;
            PB_OUT <= 8'h00;
            PC_OUT <= 8'h00;
            PD_OUT <= 2'h0;
            PA_OE_N <= 8'hFF;
            PB_OE_N <= 8'hFF;
            PC_OE_N <= 8'hFF;
            PD_OE_N <= 2'h3;
            PA_SLEW_FAST <= 8'h00;
            PB_SLEW_FAST <= 8'h00;
            PD_SLEW_FAST <= 2'h0;
            DIN_A <= 8'h00;
            DIN_B <= 8'h00;
            DIN_C <= 8'h00;
            DIN_D <= 2'h0;
            PERIPH_RDATA <= 8'h00;
        end else if (CLK_EN) begin
            PA_OUT <= pa_out_nxt;
            PB_OUT <= pb_out_nxt;
            PC_OUT <= pc_out_nxt;
            PD_OUT <= pd_out_nxt;
            PA_OE_N <= pa_oe_n_nxt;
            PB_OE_N <= pb_oe_n_nxt;
            PC_OE_N <= pc_oe_n_nxt;
            PD_OE_N <= pd_oe_n_nxt;
            PA_SLEW_FAST <= pa_slew_nxt;
            PB_SLEW_FAST <= pb_slew_nxt;
            PD_SLEW_FAST <= pd_slew_nxt;
            DIN_A <= din_a_nxt;
            DIN_B <= din_b_nxt;
            DIN_C <= din_c_nxt;
            DIN_D <= din_d_nxt;
            PERIPH_RDATA <= periph_nxt;
        end
    end

endmodule // ioc_port_cfg

////////////////////////////////////////////////////////////////////////////////
// one group of pin drivers: an open-drain pin only ever pulls low

module ioc_pin_drv #(
    parameter int W = 8
) (
    input wire logic [W-1:0] en,
    input wire logic [W-1:0] data,
    input wire logic [W-1:0] od,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n
);

    always_comb begin
        pin_out = data & ~od;
        pin_oe_n = ~(en & ~(od & data));
    end

endmodule // ioc_pin_drv

`default_nettype wire

// ### ioc_port_cfg_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ioc_port_cfg_properties (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic IO_SPACE_SEL,
    input wire logic [7:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic [7:0] BUS_WDATA,
    input wire logic [7:0] BUS_RDATA,
    input wire logic PROGRAM_STORE_STROBE,
    input wire logic [7:0] PERIPH_RDATA,
    input wire logic [7:0] OE_TERM_B,
    input wire logic [7:0] PC_IN,
    input wire logic [7:0] PA_OE_N,
    input wire logic [7:0] PB_OE_N,
    input wire logic [7:0] PA_SLEW_FAST,
    input wire logic [7:0] PB_SLEW_FAST,
    input wire logic [7:0] DIN_C
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    wire logic wr_go = CLK_EN && IO_SPACE_SEL && BUS_WR;
    wire logic rd_go = CLK_EN && IO_SPACE_SEL && BUS_RD;
    sequence s_wr(logic [7:0] a);
        wr_go && BUS_ADDR == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        rd_go && BUS_ADDR == a;
    endsequence
    property p_read_back;
        logic [7:0] d;
        (s_wr(ioc_pkg::OFS_DIR_A), d = BUS_WDATA) ##1 !wr_go ##1 s_rd(ioc_pkg::OFS_DIR_A)
            |=> BUS_RDATA == d;
    endproperty
    // only the low nibble: upper bits of port b may be open drain
    property p_dir_oe;
        logic [7:0] d, o;
        (s_wr(ioc_pkg::OFS_DIR_B), d = BUS_WDATA) ##1 (CLK_EN && !wr_go, o = OE_TERM_B)
            |=> PB_OE_N[3:0] == ~(d[3:0] | o[3:0]);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data differs from written value");
    a_dir_drives: assert property (p_dir_oe)
        else $error("driver enable is not direction or term");
    a_unmapped_zero: assert property (rd_go && BUS_ADDR inside {8'h02, 8'h03} |=> BUS_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_reset_idle: assert property ($rose(RESET_N) |-> PA_OE_N == 8'hFF && PB_SLEW_FAST == 8'h00)
        else $error("outputs not idle after reset");
    a_pd_mask: assert property (s_rd(ioc_pkg::OFS_DIR_D) or s_rd(ioc_pkg::OFS_DRV_D)
        |=> (BUS_RDATA & ~ioc_pkg::PD_USED_MASK) == 8'h00)
        else $error("unused port d bits read back");
    a_din_follow: assert property (CLK_EN |=> DIN_C == $past(PC_IN))
        else $error("input buffer lags pin");
    a_slew_upper: assert property (PA_SLEW_FAST[7:4] == 4'h0 && PB_SLEW_FAST[7:4] == 4'h0)
        else $error("slew on open drain bit");
    a_strobe_gate: assert property (CLK_EN && !PROGRAM_STORE_STROBE |=> PERIPH_RDATA == 8'h00)
        else $error("buffer read without strobe");
endmodule // ioc_port_cfg_properties
bind ioc_port_cfg ioc_port_cfg_properties ioc_port_cfg_properties_inst (.*);
`default_nettype wire

// ### ioc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module ioc_pin_model #(
    parameter int W = 8,
    parameter int KIND = 0
) (
    input wire logic clk,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] lvl
);
    // released pin: 0 far device drives ext, 1 pull-up, 2 floating (never a stale value)
    logic [W-1:0] last_r = '0;
    always @(posedge clk) begin
        last_r <= lvl;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl[i] = !oe_n[i] ? out[i] : (KIND == 0) ? ext[i] : (KIND == 1) ? 1'b1 : ~last_r[i];
        end
    end
endmodule // ioc_pin_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, sel = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic mrd = 1'b0, psa = 1'b0, psb = 1'b0, stb = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, al = 8'h00, md = 8'h00, oeb = 8'h00;
    logic [7:0] da = 8'h00, db = 8'h00, dc = 8'h00, ea = 8'h00, eb = 8'h00;
    logic [7:0] rdata, prd, pa_o, pb_o, pc_o, pa_e, pb_e, pc_e, pa_s, pb_s, pa_i, pb_i, pc_i;
    logic [7:0] din_a, din_b, din_c;
    logic [1:0] pd_o, pd_e, pd_s, pd_i, din_d;
    logic [7:0] oea = 8'h00, oec = 8'h00;
    logic [1:0] dd = 2'h1, oed = 2'h0;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    ioc_port_cfg ioc_port_cfg_inst (
        .CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .IO_SPACE_SEL(sel), .BUS_ADDR(addr),
        .BUS_WR(wr_s), .BUS_RD(rd_s), .BUS_WDATA(wd), .BUS_RDATA(rdata), .ADDR_LATCHED(al),
        .MCU_DATA(md), .MCU_READ(mrd), .PERIPH_SELECT_A(psa), .PERIPH_SELECT_B(psb),
        .PROGRAM_STORE_STROBE(stb), .PERIPH_RDATA(prd), .DOUT_A(da), .DOUT_B(db), .DOUT_C(dc),
        .DOUT_D(dd), .OE_TERM_A(oea), .OE_TERM_B(oeb), .OE_TERM_C(oec), .OE_TERM_D(oed),
        .PA_IN(pa_i), .PB_IN(pb_i), .PC_IN(pc_i), .PD_IN(pd_i), .PA_OUT(pa_o), .PB_OUT(pb_o),
        .PC_OUT(pc_o), .PD_OUT(pd_o), .PA_OE_N(pa_e), .PB_OE_N(pb_e), .PC_OE_N(pc_e),
        .PD_OE_N(pd_e), .PA_SLEW_FAST(pa_s), .PB_SLEW_FAST(pb_s), .PD_SLEW_FAST(pd_s),
        .DIN_A(din_a), .DIN_B(din_b), .DIN_C(din_c), .DIN_D(din_d));
    ioc_pin_model pa_m (.clk(clk), .out(pa_o), .oe_n(pa_e), .ext(ea), .lvl(pa_i));
    ioc_pin_model pb_m (.clk(clk), .out(pb_o), .oe_n(pb_e), .ext(eb), .lvl(pb_i));
    ioc_pin_model #(.KIND(1)) pc_m (.clk(clk), .out(pc_o), .oe_n(pc_e), .ext(8'h00), .lvl(pc_i));
    ioc_pin_model #(.W(2), .KIND(2)) pd_m (.clk(clk), .out(pd_o), .oe_n(pd_e), .ext(2'h0), .lvl(pd_i));
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {sel, wr_s, addr, wd} = {2'b11, a, d};
        @(negedge clk);
        {sel, wr_s} = 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        {sel, rd_s, addr} = {2'b11, a};
        @(negedge clk);
        {sel, rd_s} = 2'b00;
        chk(rdata, exp);
    endtask
    // config reaches the pins one edge after the write, the input buffer one more
    task automatic tick();
        repeat (2) @(negedge clk);
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] e;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk(pa_e, 8'hFF);
        for (int i = 0; i < 14; i++) begin
            rd(8'(i), 8'h00);
            wr(8'(i), 8'hFF);
            e = (i inside {2, 3, 13}) ? 8'h00 : (i inside {7, 11}) ? 8'h06 : 8'hFF;
            rd(8'(i), (i == 12) ? 8'h80 : e);
            wr(8'(i), 8'h00);
        end
        en = 1'b0;
        wr(ioc_pkg::OFS_DIR_A, 8'hFF);
        en = 1'b1;
        rd(ioc_pkg::OFS_DIR_A, 8'h00);
        db = 8'h5A;
        oeb = 8'h30;
        eb = 8'h80;
        wr(ioc_pkg::OFS_DIR_B, 8'h0F);
        tick();
        chk(pb_e, 8'hC0);
        chk(pb_o & 8'h3F, 8'h1A);
        chk(din_b, 8'h9A);
        oeb = 8'h00;
        al = 8'hC3;
        wr(ioc_pkg::OFS_MODE_B, 8'hF0);
        wr(ioc_pkg::OFS_DIR_B, 8'hFF);
        tick();
        chk(pb_o, 8'hCA);
        wr(ioc_pkg::OFS_DRV_B, 8'hFF);
        tick();
        chk(pb_s, 8'h0F);
        chk(pb_e, 8'hC0);
        chk(pb_o, 8'h0A);
        dc = 8'h0F;
        wr(ioc_pkg::OFS_DRV_C, 8'hFF);
        wr(ioc_pkg::OFS_DIR_C, 8'hFF);
        tick();
        chk(pc_e, 8'h0F);
        chk(din_c, 8'h0F);
        chk(pc_o, 8'h00);
        wr(ioc_pkg::OFS_DRV_D, 8'h04);
        wr(ioc_pkg::OFS_DIR_D, 8'h02);
        tick();
        chk({6'h00, pd_s}, 8'h02);
        chk({6'h00, pd_e}, 8'h02);
        chk({6'h00, pd_o}, 8'h01);
        oed = 2'h2;
        tick();
        chk({6'h00, pd_e}, 8'h00);
        chk({6'h00, din_d}, 8'h01);
        oea = 8'h81;
        wr(ioc_pkg::OFS_DRV_A, 8'hA5);
        tick();
        chk(pa_s, 8'h05);
        chk(pa_e, 8'h7E);
        md = 8'h3C;
        ea = 8'h96;
        {psa, psb, stb} = 3'b101;
        wr(ioc_pkg::OFS_DIR_A, 8'hFF);
        wr(ioc_pkg::OFS_MEM_MAP, 8'h80);
        tick();
        chk(pa_e, 8'hFF);
        {psa, psb, stb} = 3'b110;
        tick();
        chk(pa_e, 8'hFF);
        stb = 1'b1;
        tick();
        chk(pa_e, 8'h00);
        chk(pa_o, 8'h3C);
        chk(din_a, 8'h3C);
        mrd = 1'b1;
        tick();
        chk(prd, 8'h96);
        rst_n = 1'b0;
        @(negedge clk);
        chk(pb_s, 8'h00);
        chk(prd, 8'h00);
        rst_n = 1'b1;
        rd(ioc_pkg::OFS_DRV_A, 8'h00);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
